// *** hdl/boot_loader_map.svh ***
/*
 Constants of the boot mode select loader: kernel size, word layout, strap timing.
 Assumes inclusion by bare name from the loader module, the monitor and the bench.
*/
`ifndef BOOT_LOADER_MAP_SVH
`define BOOT_LOADER_MAP_SVH
`define BOOT_KERNEL_WORDS 256
`define BOOT_WORD_BITS 32
`define BOOT_BYTE_BITS 8
`define BOOT_BYTES_PER_WORD 4
`define BOOT_ADDR_BITS 8
`define BOOT_STRAP_SAMPLE_CYCLES 16
`define BOOT_CNT_BITS 8
`endif

// *** hdl/boot_loader_pkg.sv ***
/*
 Types of the boot mode select loader.
 Assumes the map header sits beside it.
*/
package boot_loader_pkg;
    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_EPROM,
        SRC_HOST,
        SRC_LINK
    } boot_src_t;
    typedef enum {
        ST_RESET,
        ST_STRAP_WAIT,
        ST_EPROM_READ,
        ST_IDLE_WAIT,
        ST_STREAM,
        ST_RUN
    } boot_state_t;
endpackage

// *** hdl/boot_mode_select_loader.sv ***
/*
 Reset-time boot loader: samples the boot select strap, then fills the
 256-word kernel memory over one DMA write channel from an 8-bit EPROM,
 a host writing the auto DMA port register, or a peer on the link port.
 Assumes host and link strobes are on clk; strap and EPROM data come from pins.
*/
//
// Behaviour
// - At reset, load a 256-instruction boot kernel into internal memory before application.
// - While reset is held, the boot select strap pin is an input.
// - Strap low selects EPROM boot; afterwards pin drives EPROM chip select.
// - Strap high enters idle, waiting for host or link boot data.
// - Boot data arrives as 32-bit words moved into memory by one DMA channel.
// - EPROM boot reads an 8-bit external EPROM through the external port.
// - After the last boot word, the device starts running the loaded code.
// - Link boot accepts boot data from a peer processor on the link port.
// - The kernel region is released for reuse once the kernel has finished.
`timescale 1ns/1ns
`include "boot_loader_map.svh"

module boot_mode_select_loader #(
    parameter int KERNEL_WORDS = `BOOT_KERNEL_WORDS,
    parameter int STRAP_CYCLES = `BOOT_STRAP_SAMPLE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Boot select strap pin, three signals
    input wire logic bootSelectStrapIn,
    output logic bootSelectStrapOut,
    output logic bootSelectStrapOe,
    // External port toward the 8-bit EPROM
    output logic [`BOOT_WORD_BITS-1:0] epromAddr,
    output logic epromRdN,
    input wire logic [`BOOT_BYTE_BITS-1:0] epromData,
    // Host writes to the auto DMA port register
    input wire logic hostWrite,
    input wire logic [`BOOT_WORD_BITS-1:0] hostData,
    // Link port receive words from a peer
    input wire logic linkValid,
    input wire logic [`BOOT_WORD_BITS-1:0] linkData,
    // Kernel has initialised the system and frees its region
    input wire logic kernelDone,
    // DMA channel write into internal memory
    output logic dmaWrite,
    output logic [`BOOT_ADDR_BITS-1:0] dmaAddr,
    output logic [`BOOT_WORD_BITS-1:0] dmaData,
    // Status
    output logic [1:0] bootSource,
    output logic bootRun,
    output logic kernelRegionFree
);

    boot_loader_pkg::boot_state_t state_q;
    logic strapMeta_q, strapSync_q;
    logic [`BOOT_BYTE_BITS-1:0] byteMeta_q, byteSync_q;
    logic [`BOOT_CNT_BITS-1:0] strapCnt_q;
    logic [1:0] byteIdx_q;
    logic [1:0] readPhase_q;
    logic [`BOOT_WORD_BITS-1:0] wordAcc_q;
    logic [`BOOT_ADDR_BITS:0] wordCnt_q;
    logic [`BOOT_WORD_BITS-1:0] autoDmaPortReg_q;
    logic autoDmaPending_q;
    logic streamWord;
    logic [`BOOT_WORD_BITS-1:0] streamData;
    logic lastWord;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stages feed only the second
    always_ff @(posedge clk) begin
        strapMeta_q <= bootSelectStrapIn;
        strapSync_q <= strapMeta_q;
        byteMeta_q <= epromData;
        byteSync_q <= byteMeta_q;
    end

    // Word accepted by the DMA channel this cycle, host or link
    always_comb begin
        streamWord = 1'b0;
        streamData = '0;
        if (state_q == boot_loader_pkg::ST_STREAM) begin
            if (bootSource == boot_loader_pkg::SRC_HOST) begin
                streamWord = autoDmaPending_q;
                streamData = autoDmaPortReg_q;
            end else begin
                streamWord = linkValid;
                streamData = linkData;
            end
        end
    end

    // Final kernel word leaving on the DMA channel; keyed on the address so gaps between words do no harm
    assign lastWord = dmaWrite && (dmaAddr == `BOOT_ADDR_BITS'(KERNEL_WORDS - 1));

    ////////////////////////////////////////////////////////////////////////////
    // Boot sequencer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= boot_loader_pkg::ST_RESET;
            strapCnt_q <= '0;
            bootSource <= boot_loader_pkg::SRC_NONE;
            bootRun <= 1'b0;
        end else begin
            case (state_q)
                boot_loader_pkg::ST_RESET: begin
                    state_q <= boot_loader_pkg::ST_STRAP_WAIT;
                end
                boot_loader_pkg::ST_STRAP_WAIT: begin
                    // Single sample; the count allows the synchroniser to settle
                    if (strapCnt_q == `BOOT_CNT_BITS'(STRAP_CYCLES - 1)) begin
                        if (!strapSync_q) begin
                            state_q <= boot_loader_pkg::ST_EPROM_READ;
                            bootSource <= boot_loader_pkg::SRC_EPROM;
                        end else begin
                            state_q <= boot_loader_pkg::ST_IDLE_WAIT;
                        end
                    end else begin
                        strapCnt_q <= strapCnt_q + 1'b1;
                    end
                end
                boot_loader_pkg::ST_IDLE_WAIT: begin
                    // First source to speak owns the boot
                    if (hostWrite) begin
                        state_q <= boot_loader_pkg::ST_STREAM;
                        bootSource <= boot_loader_pkg::SRC_HOST;
                    end else if (linkValid) begin
                        state_q <= boot_loader_pkg::ST_STREAM;
                        bootSource <= boot_loader_pkg::SRC_LINK;
                    end
                end
                boot_loader_pkg::ST_EPROM_READ, boot_loader_pkg::ST_STREAM: begin
                    if (lastWord) begin
                        state_q <= boot_loader_pkg::ST_RUN;
                        bootRun <= 1'b1;
                    end
                end
                boot_loader_pkg::ST_RUN: begin
                    bootRun <= 1'b1;
                end
                default: begin
                    state_q <= boot_loader_pkg::ST_RESET;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strap pin: input through reset and sampling, chip select after EPROM pick
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bootSelectStrapOe <= 1'b0;
            bootSelectStrapOut <= 1'b1;
        end else begin
            bootSelectStrapOe <= (state_q == boot_loader_pkg::ST_EPROM_READ);
            bootSelectStrapOut <= !(state_q == boot_loader_pkg::ST_EPROM_READ);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host auto DMA port register; holds one word until the channel takes it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            autoDmaPortReg_q <= '0;
            autoDmaPending_q <= 1'b0;
        end else if (hostWrite && (state_q == boot_loader_pkg::ST_IDLE_WAIT
                     || state_q == boot_loader_pkg::ST_STREAM)) begin
            autoDmaPortReg_q <= hostData;
            autoDmaPending_q <= 1'b1;
        end else begin
            autoDmaPending_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // EPROM reader: four-cycle byte read covers the two-flop data path
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            epromAddr <= '0;
            epromRdN <= 1'b1;
            readPhase_q <= '0;
            byteIdx_q <= '0;
            wordAcc_q <= '0;
        end else if (state_q == boot_loader_pkg::ST_EPROM_READ) begin
            epromRdN <= 1'b0;
            readPhase_q <= readPhase_q + 1'b1;
            if (readPhase_q == 2'h3) begin
                // Bytes pack least significant first into one word
                wordAcc_q <= {byteSync_q, wordAcc_q[`BOOT_WORD_BITS-1:`BOOT_BYTE_BITS]};
                byteIdx_q <= byteIdx_q + 1'b1;
                epromAddr <= epromAddr + 1'b1;
            end
        end else begin
            epromRdN <= 1'b1;
            readPhase_q <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // DMA channel: one write per 32-bit word into the kernel region
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dmaWrite <= 1'b0;
            dmaAddr <= '0;
            dmaData <= '0;
            wordCnt_q <= '0;
        end else begin
            dmaWrite <= 1'b0;
            if (state_q == boot_loader_pkg::ST_EPROM_READ && readPhase_q == 2'h3
                && byteIdx_q == 2'h3) begin
                dmaWrite <= 1'b1;
                dmaData <= {byteSync_q, wordAcc_q[`BOOT_WORD_BITS-1:`BOOT_BYTE_BITS]};
                dmaAddr <= wordCnt_q[`BOOT_ADDR_BITS-1:0];
                wordCnt_q <= wordCnt_q + 1'b1;
            end else if (streamWord) begin
                dmaWrite <= 1'b1;
                dmaData <= streamData;
                dmaAddr <= wordCnt_q[`BOOT_ADDR_BITS-1:0];
                wordCnt_q <= wordCnt_q + 1'b1;
            end
            if (lastWord) begin
                wordCnt_q <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Kernel region released to the application once the kernel reports done
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            kernelRegionFree <= 1'b0;
        end else if (bootRun && kernelDone) begin
            kernelRegionFree <= 1'b1;
        end
    end

endmodule // boot_mode_select_loader

// *** tb/boot_loader_monitor.sv ***
/*
 Port checker of the boot mode select loader.
 Assumes it is bound to boot_mode_select_loader on clk and sys_rst.
*/
`timescale 1ns/1ns
`include "boot_loader_map.svh"
module boot_loader_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Strap pin and external port
    input wire logic bootSelectStrapOut,
    input wire logic bootSelectStrapOe,
    input wire logic [`BOOT_WORD_BITS-1:0] epromAddr,
    input wire logic epromRdN,
    // Boot word sources and kernel done
    input wire logic hostWrite,
    input wire logic [`BOOT_WORD_BITS-1:0] hostData,
    input wire logic linkValid,
    input wire logic [`BOOT_WORD_BITS-1:0] linkData,
    input wire logic kernelDone,
    // DMA and status
    input wire logic dmaWrite,
    input wire logic [`BOOT_ADDR_BITS-1:0] dmaAddr,
    input wire logic [`BOOT_WORD_BITS-1:0] dmaData,
    input wire logic [1:0] bootSource,
    input wire logic bootRun,
    input wire logic kernelRegionFree
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////
    // Words taken once the mode is known; the first word of each source is left out
    sequence hostTake; hostWrite && bootSource == 2'h2 && !bootRun; endsequence
    sequence linkTake; linkValid && bootSource == 2'h3 && !bootRun; endsequence
    // Reset values hold even while reset is asserted, so no disable here
    rst_idle_a: assert property (disable iff (1'b0) sys_rst |=>
        !bootSelectStrapOe && epromRdN && !dmaWrite && !bootRun) else $error("outputs not idle in reset");
    cs_mode_a: assert property (bootSelectStrapOe |-> bootSource == 2'h1) else $error("strap driven off mode");
    cs_stands_a: assert property ($fell(bootSelectStrapOe) |-> bootRun) else $error("chip select dropped early");
    read_select_a: assert property (!epromRdN |-> bootSelectStrapOe && !bootSelectStrapOut)
        else $error("read without chip select");
    addr_hold_a: assert property ($changed(epromAddr) |=> $stable(epromAddr)[*3]) else $error("address too short");
    host_word_a: assert property (hostTake |-> ##2 dmaWrite && dmaData == $past(hostData, 2))
        else $error("host word not moved");
    link_word_a: assert property (linkTake |=> dmaWrite && dmaData == $past(linkData))
        else $error("link word not moved");
    run_start_a: assert property (dmaWrite && dmaAddr == 8'hFF |=> bootRun) else $error("no run after last word");
    run_quiet_a: assert property (bootRun |-> !dmaWrite) else $error("write after run");
    free_set_a: assert property (bootRun && kernelDone |=> kernelRegionFree) else $error("region not freed");
    free_cause_a: assert property ($rose(kernelRegionFree) |-> $past(bootRun) && $past(kernelDone))
        else $error("region freed early");
endmodule // boot_loader_monitor
bind boot_mode_select_loader boot_loader_monitor mon (.clk, .sys_rst, .bootSelectStrapOut, .bootSelectStrapOe,
    .epromAddr, .epromRdN, .hostWrite, .hostData, .linkValid, .linkData, .kernelDone, .dmaWrite, .dmaAddr,
    .dmaData, .bootSource, .bootRun, .kernelRegionFree);

// *** tb/eprom_model.sv ***
/*
 Byte-wide boot memory on the external port.
 Assumes active-low chip select and read strobe.
*/
`timescale 1ns/1ns
module eprom_model (
    // Port from the loader
    input wire logic [31:0] addr,
    input wire logic csN,
    input wire logic rdN,
    // Byte back
    output logic [7:0] data
);
    logic [7:0] lastQ = 8'h00;
    logic [7:0] val;
    // Contents follow the address; a released bus shows the inverse of the last byte
    assign val = addr[7:0] ^ {6'h00, addr[9:8]};
    always @* if (!csN && !rdN) lastQ = val;
    assign data = (!csN && !rdN) ? val : ~lastQ;
endmodule // eprom_model

// *** tb/tb_boot_mode_select_loader.sv ***
/*
 Bench of the boot loader: EPROM, host and link boots.
 Assumes the monitor binds itself and the memory model sits beside it.
*/
`timescale 1ns/1ns
`include "boot_loader_map.svh"
module tb_boot_mode_select_loader;
    localparam int S = 4;
    logic clk = 0, sys_rst = 1, strap = 0, hostWrite = 0, linkValid = 0, kernelDone = 0;
    logic [31:0] hostData = 32'h0, linkData = 32'h0, epromAddr, dmaData;
    logic [7:0] epromData, dmaAddr;
    logic [1:0] bootSource;
    logic strapOut, strapOe, epromRdN, dmaWrite, bootRun, kernelRegionFree;
    int bad_count = 0, num_checks = 0, wrCnt = 0;
    always #5 clk = ~clk;
    eprom_model rom (.addr(epromAddr), .csN(strapOe ? strapOut : 1'b1), .rdN(epromRdN), .data(epromData));
    boot_mode_select_loader #(.STRAP_CYCLES(S)) dut (.clk(clk), .sys_rst(sys_rst),
        .bootSelectStrapIn(strapOe ? strapOut : strap), .bootSelectStrapOut(strapOut), .bootSelectStrapOe(strapOe),
        .epromAddr(epromAddr), .epromRdN(epromRdN), .epromData(epromData), .hostWrite(hostWrite),
        .hostData(hostData), .linkValid(linkValid), .linkData(linkData), .kernelDone(kernelDone),
        .dmaWrite(dmaWrite), .dmaAddr(dmaAddr), .dmaData(dmaData), .bootSource(bootSource), .bootRun(bootRun),
        .kernelRegionFree(kernelRegionFree));
    ////////////////////////////////////////////////////////////////
    // Expected word n, bytes packed low first
    function automatic logic [31:0] word(int n);
        logic [31:0] w;
        for (int k = 0; k < 4; k++) w[8*k+:8] = 8'((4*n+k) % 256) ^ 8'((4*n+k) / 256);
        return w;
    endfunction
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic test_done();
        if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Every DMA write must land at the next address; sampled mid-cycle to avoid edge races
    always @(negedge clk) if (dmaWrite === 1'b1) begin
        chk("dmaAddr", wrCnt, dmaAddr);
        chk("dmaData", word(wrCnt), dmaData);
        wrCnt++;
    end
    ////////////////////////////////////////////////////////////////
    task automatic restart(logic level);
        sys_rst = 1;
        strap = level;
        wrCnt = 0;
        repeat (6) @(posedge clk);
        #1 sys_rst = 0;
    endtask
    task automatic wait_run();
        int i;
        for (i = 0; i < 9000 && bootRun !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 9000) begin
            bad_count++;
            test_done();
        end
    endtask
    task automatic send(logic viaLink, int first, int count);
        for (int i = first; i < first + count; i++) begin
            hostWrite = !viaLink;
            linkValid = viaLink;
            hostData = word(i);
            linkData = word(i);
            @(posedge clk);
            #1;
        end
        hostWrite = 0;
        linkValid = 0;
    endtask
    task automatic test_eprom();
        restart(0);
        repeat (S + 1) @(posedge clk);
        #1 chk("strapOe early", 0, strapOe);
        @(posedge clk);
        #1 chk("strapOe", 1, strapOe);
        chk("strapOut", 0, strapOut);
        wait_run();
        chk("source", 1, bootSource);
        chk("words", 256, wrCnt);
        chk("epromAddr", 1024, epromAddr);
        chk("free early", 0, kernelRegionFree);
        kernelDone = 1;
        @(posedge clk);
        #1 kernelDone = 0;
        chk("free", 1, kernelRegionFree);
    endtask
    // Host or link boot; a late word after run must be refused
    task automatic test_stream(logic viaLink);
        restart(1);
        repeat (S + 2) @(posedge clk);
        #1;
        if (viaLink) begin
            send(1, 300, 1);
            @(posedge clk);
            #1;
        end
        send(viaLink, 0, 256);
        wait_run();
        send(viaLink, 256, 1);
        repeat (3) @(posedge clk);
        #1 chk("words", 256, wrCnt);
        chk("source", viaLink ? 3 : 2, bootSource);
        chk("strapOe", 0, strapOe);
        chk("free", 0, kernelRegionFree);
    endtask
    initial begin
        test_eprom();
        test_stream(0);
        test_stream(1);
        test_done();
    end
endmodule // tb_boot_mode_select_loader
